//--- verilog/rcm_defines.vh
// constants for the reset and clock mode control block
`ifndef RCM_DEFINES_VH
`define RCM_DEFINES_VH
// minimum reset low time in main oscillator cycles
`define RCM_RESET_MIN_CYC    5'h10
`define RCM_RESET_CNT_W      5
// reset vector addresses
`define RCM_VEC_LO_ADDR      16'hFFFC
`define RCM_VEC_HI_ADDR      16'hFFFD
// register reset values
`define RCM_CLEAR_VAL        8'h00
`define RCM_WDT_RESET_VAL    8'h3F
`define RCM_PS_IRQ_DIS_BIT   2
// divider end counts (ratio minus one) and half-period high thresholds
`define RCM_DIV_MID_LAST     3'h7
`define RCM_DIV_HIGH_LAST    3'h1
`define RCM_DIV_HALF_MID     3'h4
`define RCM_DIV_HALF_HIGH    3'h1
`endif

//--- verilog/rcm_clock_divider.v
// glitch-free main clock divider for middle and high speed modes
`include "rcm_defines.vh"

module rcm_clock_divider (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       high_speed,
    output reg        phi_q,
    output reg        phi_edge_q,
    output reg        high_speed_active_q
);

    reg [2:0] cnt_q;
    reg [2:0] cnt_d;
    reg       mode_d;

    // ratio changes only at the end of a full phase, so no pulse is shortened
    always @* begin
        cnt_d  = cnt_q + 3'h1;
        mode_d = high_speed_active_q;
        if (cnt_q == (high_speed_active_q ? `RCM_DIV_HIGH_LAST : `RCM_DIV_MID_LAST)) begin
            cnt_d  = 3'h0;
            mode_d = high_speed;                                        // [RULE13]
        end
    end

    // divide by 8 after reset, by 2 when high speed is active
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q               <= 3'h0;
            high_speed_active_q <= 1'b0;                                // [RULE9]
            phi_q               <= 1'b0;
            phi_edge_q          <= 1'b0;
        end else begin
            cnt_q               <= cnt_d;
            high_speed_active_q <= mode_d;
            phi_q               <= (cnt_d < (mode_d ? `RCM_DIV_HALF_HIGH :
                                    `RCM_DIV_HALF_MID));                // [RULE9] [RULE10]
            phi_edge_q          <= (cnt_d == 3'h0);
        end
    end

endmodule // rcm_clock_divider

//--- verilog/rcm_reset_clock_ctrl.v
// reset sequencing and system clock mode control
// Notes on behaviour
// RULE1: source holds reset low sixteen oscillator cycles
// RULE2: stay in reset while input low
// RULE3: load program counter from vector bytes
// RULE4: clear listed port, control, status registers
// RULE5: watchdog control resets to 0x3F
// RULE6: host buffers and irq request untouched
// RULE7: other registers and RAM undefined
// RULE8: only main oscillator starts at power-on
// RULE9: middle speed divides by eight, default
// RULE10: high speed divides by two
// RULE11: software stabilises oscillator before switching
// RULE12: status undefined except interrupt disable set
// RULE13: divider ratio changes only at boundary
`include "rcm_defines.vh"

module rcm_reset_clock_ctrl (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        reset_in_n,
    input  wire        high_speed_req,
    input  wire        sub_osc_enable,
    input  wire [7:0]  vec_rdata,
    output reg  [15:0] vec_addr_q,
    output reg         vec_rd_q,
    output reg  [15:0] pc_q,
    output reg         pc_valid_q,
    output reg         core_reset_q,
    output reg         reg_clear_q,
    output reg  [7:0]  clear_value_q,
    output reg  [7:0]  watchdog_control_q,
    output reg  [7:0]  processor_status_set_q,
    output reg         sub_osc_run_q,
    output reg         main_osc_run_q,
    output reg         phi_q,
    output reg         phi_edge_q,
    output reg         high_speed_q
);

    // ============================================================
    // reset synchroniser
    // ============================================================
    // assertion stays asynchronous, release is retimed so no flop sees
    // reset lift inside its setup window; costs two cycles after power-up
    reg rst_s1_q;
    reg rst_s2_q;
    wire srst_n = rst_s2_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ============================================================
    // reset sequencer
    // ============================================================
    // one-hot states: held, low vector byte, high vector byte, running
    localparam [3:0] ST_HOLD = 4'b0001;
    localparam [3:0] ST_LO   = 4'b0010;
    localparam [3:0] ST_HI   = 4'b0100;
    localparam [3:0] ST_RUN  = 4'b1000;

    reg [3:0]                  state_q;
    reg [3:0]                  state_d;
    reg [`RCM_RESET_CNT_W-1:0] low_cnt_q;
    reg                        qualified_q;
    reg [7:0]                  pcl_q;

    // the sixteenth consecutive low sample is the minimum legal pulse
    wire min_low_w = (low_cnt_q == `RCM_RESET_MIN_CYC - 5'h01);
    // qualifying on that sample lets the core enter reset while the pin is
    // still low, even when the pulse is exactly the minimum length
    wire qual_now_w = qualified_q | min_low_w;

    // hold decode shared by the clear, mode and oscillator logic
    function is_hold;
        input [3:0] st;
        begin
            is_hold = (st == ST_HOLD);
        end
    endfunction

    // short glitches below the minimum low time do not reset the core
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            low_cnt_q   <= {`RCM_RESET_CNT_W{1'b0}};
            qualified_q <= 1'b1;
        end else if (!reset_in_n) begin
            // the count stops at the minimum so a long low never wraps round
            if (low_cnt_q != `RCM_RESET_MIN_CYC)
                low_cnt_q <= low_cnt_q + 5'h01;
            if (min_low_w)
                qualified_q <= 1'b1;                                    // [RULE1]
        end else begin
            low_cnt_q   <= {`RCM_RESET_CNT_W{1'b0}};
            qualified_q <= 1'b0;
        end
    end

    // next-state decode of the vector fetch sequence
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_HOLD: if (reset_in_n && qualified_q) state_d = ST_LO;  // [RULE2]
            ST_LO:   state_d = ST_HI;
            ST_HI:   state_d = ST_RUN;
            ST_RUN:  state_d = ST_RUN;
            default: state_d = ST_HOLD;
        endcase
        // a qualified low forces hold from any state while the pin is low
        if (!reset_in_n && qual_now_w)
            state_d = ST_HOLD;                                          // [RULE2]
    end

    // vector fetch: address goes out one cycle, data returns the next
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            state_q    <= ST_HOLD;
            vec_addr_q <= `RCM_VEC_LO_ADDR;
            vec_rd_q   <= 1'b0;
            pcl_q      <= 8'h00;
            pc_q       <= 16'h0000;
            pc_valid_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            vec_rd_q <= 1'b0;
            case (state_d)
                ST_LO: begin
                    vec_addr_q <= `RCM_VEC_LO_ADDR;                     // [RULE3]
                    vec_rd_q   <= 1'b1;
                end
                ST_HI: begin
                    vec_addr_q <= `RCM_VEC_HI_ADDR;                     // [RULE3]
                    vec_rd_q   <= 1'b1;
                    pcl_q      <= vec_rdata;
                end
                ST_RUN: begin
                    if (state_q == ST_HI) begin
                        pc_q       <= {vec_rdata, pcl_q};               // [RULE3]
                        pc_valid_q <= 1'b1;
                    end
                end
                default: begin
                    pc_valid_q <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // register reset values handed to the core
    // ============================================================
    // only the listed registers get a clear; host buffers and serial irq
    // request are deliberately never touched, nor are other registers/RAM
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            core_reset_q           <= 1'b1;
            reg_clear_q            <= 1'b1;
            clear_value_q          <= `RCM_CLEAR_VAL;
            watchdog_control_q     <= `RCM_WDT_RESET_VAL;
            processor_status_set_q <= 8'h00;
        end else begin
            core_reset_q           <= (state_d != ST_RUN);              // [RULE2]
            reg_clear_q            <= is_hold(state_d);                 // [RULE4] [RULE6] [RULE7]
            clear_value_q          <= `RCM_CLEAR_VAL;                   // [RULE4]
            watchdog_control_q     <= `RCM_WDT_RESET_VAL;               // [RULE5]
            processor_status_set_q <= 8'h01 << `RCM_PS_IRQ_DIS_BIT;     // [RULE12]
        end
    end

    // ============================================================
    // oscillators and speed mode
    // ============================================================
    reg hs_q;

    // mode request is ignored while the sequencer is in hold; reset selects middle speed
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            hs_q           <= 1'b0;                                     // [RULE9]
            main_osc_run_q <= 1'b1;                                     // [RULE8]
            sub_osc_run_q  <= 1'b0;                                     // [RULE8]
        end else begin
            hs_q           <= is_hold(state_d) ? 1'b0 : high_speed_req;
            main_osc_run_q <= 1'b1;
            // the second oscillator never starts by itself; software enables it
            sub_osc_run_q  <= is_hold(state_d) ? 1'b0 : sub_osc_enable;   // [RULE8]
        end
    end

    wire phi_w;
    wire phi_edge_w;
    wire hs_active_w;

    rcm_clock_divider u_div (
        .ref_clk             (ref_clk),
        .rst_n               (srst_n),
        .high_speed          (hs_q),
        .phi_q               (phi_w),
        .phi_edge_q          (phi_edge_w),
        .high_speed_active_q (hs_active_w)
    );

    // register divider outputs so every port comes from a flip-flop; phi and
    // its edge marker both lag one cycle, so they stay aligned with the mode
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            phi_q        <= 1'b0;
            phi_edge_q   <= 1'b0;
            high_speed_q <= 1'b0;
        end else begin
            phi_q        <= phi_w;
            phi_edge_q   <= phi_edge_w;
            high_speed_q <= hs_active_w;                                // [RULE13]
        end
    end

endmodule // rcm_reset_clock_ctrl

//--- verif/rcm_reset_clock_ctrl_assertions.sv
// concurrent checks on the reset and clock mode control ports
module rcm_reset_clock_ctrl_assertions (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        reset_in_n,
    input wire logic        high_speed_req,
    input wire logic        sub_osc_enable,
    input wire logic [7:0]  vec_rdata,
    input wire logic [15:0] vec_addr_q,
    input wire logic        vec_rd_q,
    input wire logic [15:0] pc_q,
    input wire logic        pc_valid_q,
    input wire logic        core_reset_q,
    input wire logic        reg_clear_q,
    input wire logic [7:0]  clear_value_q,
    input wire logic [7:0]  watchdog_control_q,
    input wire logic [7:0]  processor_status_set_q,
    input wire logic        sub_osc_run_q,
    input wire logic        main_osc_run_q,
    input wire logic        phi_q,
    input wire logic        phi_edge_q,
    input wire logic        high_speed_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // consecutive low samples of the reset pin, saturating so long lows never wrap
    logic [4:0] low_cnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) low_cnt_q <= 5'h00;
        else if (reset_in_n) low_cnt_q <= 5'h00;
        else if (low_cnt_q != 5'h1F) low_cnt_q <= low_cnt_q + 5'h01;
    end
    // =========================================================
    // reset pin, vector fetch, reset values, oscillator run levels
    a_short_low_kept: assert property (
        pc_valid_q && !reset_in_n && low_cnt_q < 5'h0F |=> pc_valid_q)
        else $error("short reset pulse dropped the program counter");
    a_long_low_held: assert property (
        low_cnt_q == 5'h10 |-> core_reset_q && !pc_valid_q)
        else $error("long reset pulse did not hold the core");
    a_fetch_order: assert property ($rose(vec_rd_q) |-> vec_addr_q == 16'hFFFC ##1
        vec_rd_q && vec_addr_q == 16'hFFFD ##1 !vec_rd_q && pc_valid_q && !core_reset_q)
        else $error("vector fetch order or timing wrong");
    a_pc_from_bytes: assert property ($rose(pc_valid_q) |->
        pc_q == {$past(vec_rdata), $past(vec_rdata, 2)})
        else $error("program counter not built from vector bytes");
    a_release_values: assert property ($fell(core_reset_q) |->
        watchdog_control_q == 8'h3F && processor_status_set_q[2] && !reg_clear_q)
        else $error("wrong watchdog or status value at release");
    a_clear_zero: assert property (reg_clear_q |-> clear_value_q == 8'h00)
        else $error("clear value not zero");
    a_sub_osc_off: assert property (
        !sub_osc_enable [*3] |-> !sub_osc_run_q && main_osc_run_q)
        else $error("oscillator run levels wrong");
    // =========================================================
    // divider periods and switching
    a_mid_period: assert property (
        phi_edge_q && !high_speed_q |=> !phi_edge_q [*7] ##1 phi_edge_q)
        else $error("middle speed period not eight cycles");
    a_high_period: assert property (
        phi_edge_q && high_speed_q |=> !phi_edge_q ##1 phi_edge_q)
        else $error("high speed period not two cycles");
    a_mid_duty: assert property (
        phi_edge_q && !high_speed_q |-> phi_q [*4] ##1 !phi_q [*4])
        else $error("middle speed clock not high for half the period");
    a_high_duty: assert property (phi_edge_q && high_speed_q |-> phi_q ##1 !phi_q)
        else $error("high speed clock not high for half the period");
    a_mode_follows: assert property (
        $rose(high_speed_req) && !core_reset_q |-> ##[1:10] high_speed_q)
        else $error("high speed request not applied within a divider period");
    a_switch_boundary: assert property (
        $changed(high_speed_q) |-> phi_edge_q)
        else $error("mode changed away from a period boundary");
endmodule // rcm_reset_clock_ctrl_assertions

bind rcm_reset_clock_ctrl rcm_reset_clock_ctrl_assertions u_chk (.ref_clk, .rst_n, .reset_in_n,
    .high_speed_req, .sub_osc_enable, .vec_rdata, .vec_addr_q, .vec_rd_q, .pc_q, .pc_valid_q,
    .core_reset_q, .reg_clear_q, .clear_value_q, .watchdog_control_q, .processor_status_set_q,
    .sub_osc_run_q, .main_osc_run_q, .phi_q, .phi_edge_q, .high_speed_q);

//--- verif/rcm_vector_model.sv
// vector memory stand-in answering the reset block's fetch
module rcm_vector_model (
    input wire logic        ref_clk,
    input wire logic        vec_rd_q,
    input wire logic [15:0] vec_addr_q,
    input wire logic [15:0] vec_word,
    output logic     [7:0]  vec_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] junk_q = 8'h5A;
    // junk flips each cycle so an idle bus never looks like a held byte
    always @(posedge ref_clk) junk_q <= ~junk_q;
    // low byte at the low vector address, high byte one above
    always_comb begin
        if (vec_rd_q && vec_addr_q == 16'hFFFC) vec_rdata = vec_word[7:0];
        else if (vec_rd_q && vec_addr_q == 16'hFFFD) vec_rdata = vec_word[15:8];
        else vec_rdata = junk_q;
    end
endmodule // rcm_vector_model

//--- verif/rcm_reset_clock_ctrl_bench.sv
// self-checking bench for reset and clock mode control
module rcm_reset_clock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, reset_in_n = 1'b1, high_speed_req = 1'b0;
    logic sub_osc_enable = 1'b0, vec_rd_q, pc_valid_q, core_reset_q, reg_clear_q;
    logic sub_osc_run_q, main_osc_run_q, phi_q, phi_edge_q, high_speed_q;
    logic [15:0] vec_word = 16'hC0DE, exp_pc = 16'hC0DE, vec_addr_q, pc_q;
    logic [7:0]  vec_rdata, clear_value_q, watchdog_control_q, processor_status_set_q;
    logic [31:0] lfsr = 32'h3543B965;
    int          n_mismatch = 0, compares = 0, n, i, j;
    rcm_reset_clock_ctrl dut (.ref_clk, .rst_n, .reset_in_n, .high_speed_req, .sub_osc_enable,
        .vec_rdata, .vec_addr_q, .vec_rd_q, .pc_q, .pc_valid_q, .core_reset_q, .reg_clear_q,
        .clear_value_q, .watchdog_control_q, .processor_status_set_q, .sub_osc_run_q,
        .main_osc_run_q, .phi_q, .phi_edge_q, .high_speed_q);
    rcm_vector_model u_vec (.ref_clk, .vec_rd_q, .vec_addr_q, .vec_word, .vec_rdata);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // divider period expected for a mode
    function automatic logic [15:0] exp_period(input logic hs);
        return hs ? 16'h0002 : 16'h0008;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // bounded wait for a loaded program counter, then the released state
    task automatic wait_pc();
        for (n = 0; n < 20 && pc_valid_q !== 1'b1; n++) @(negedge ref_clk);
        if (n == 20) begin
            n_mismatch++;
            results();
        end
        chk("pc", exp_pc, pc_q);
        chk("run", 16'h0000, {14'h0, core_reset_q, reg_clear_q});
        chk("wdt", 16'h003F, {8'h00, watchdog_control_q});
        chk("clear", 16'h0000, {8'h00, clear_value_q});
        chk("ps_i", 16'h0001, {15'h0, processor_status_set_q[2]});
    endtask
    // pull the pin low k cycles; only a low of sixteen or more reloads
    task automatic pin_reset(input int k, input logic [15:0] w);
        vec_word <= w;
        reset_in_n <= 1'b0;
        tick(k - 1);
        @(negedge ref_clk);
        if (k > 17) chk("held", 16'h0003, {14'h0, core_reset_q, reg_clear_q});
        tick(1);
        reset_in_n <= 1'b1;
        if (k >= 16) exp_pc = w;
        @(negedge ref_clk);
        wait_pc();
    endtask
    // cycles between two period starts; a lost edge ends the run
    task automatic period(input logic hs);
        for (n = 0; n < 40 && phi_edge_q !== 1'b1; n++) @(negedge ref_clk);
        @(negedge ref_clk);
        for (i = 1; i < 40 && phi_edge_q !== 1'b1; i++) @(negedge ref_clk);
        chk("period", exp_period(hs), 16'(i));
        if (n == 40 || i == 40) begin
            n_mismatch++;
            results();
        end
    endtask
    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        tick(20);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk("osc", 16'h0001, {14'h0, sub_osc_run_q, main_osc_run_q});
        chk("mode", 16'h0000, {15'h0, high_speed_q});
        wait_pc();
        period(1'b0);
        tick(1);
        sub_osc_enable <= 1'b1;
        tick(6);
        @(negedge ref_clk);
        chk("sub_osc", 16'h0001, {15'h0, sub_osc_run_q});
        // switch only with the clock running steadily
        for (j = 0; j < 2; j++) begin
            tick(1);
            high_speed_req <= ~high_speed_req;
            tick(20);
            period(j == 0);
            chk("mode", 16'(j == 0), {15'h0, high_speed_q});
        end
        // pulse lengths of 15 and 16 cycles, then random lengths from 16 to 31 cycles
        for (j = 0; j < 6; j++) begin
            lfsr = lfsr_next(lfsr);
            tick(1);
            high_speed_req <= lfsr[8];
            pin_reset(j == 0 ? 15 : j == 1 ? 16 : 16 + lfsr[3:0], lfsr[31:16]);
        end
        tick(1);
        rst_n <= 1'b0;
        high_speed_req <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        exp_pc = vec_word;
        @(negedge ref_clk);
        wait_pc();
        period(1'b0);
        results();
    end
endmodule // rcm_reset_clock_ctrl_bench
